// ### tlia_top.sv
// Two-level interrupt aggregator with 8-bit register port.
// Assumes reads and writes are one-cycle strobes synchronous to i_sys_clk.
`timescale 1ns/100ps
`default_nettype none
//Contract
// - Single-event bit sets on status assertion.
// - Dual-event bit sets on assert and deassert.
// - Transmit parity error sets 0x40 bit 7.
// - Delineation loss and regain set 0x41 bit 7.
// - Each interrupt bit has own enable.
// - First-level masked bits OR into summary.
// - Masked summary bits OR drive the pin.
// - Control 0x00 bit 6 gates the pin.
// - Summary bit layout fixed, bit 3 reserved.
// - Source found within two register reads.
// - First-level read clears whole register.
// - One-second bit clears on summary read.
// - Other summary bits follow first-level registers.
// - One-second output pulses once per 8000 frames.
module tlia_top
  import tlia_pkg::*;
#(
  parameter int FRAMES = TLIA_FRAMES_PER_SEC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Register port
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Raw status from the line side
  input wire logic i_tx_parity_err,
  input wire logic i_cell_delin_loss,
  input wire logic [7:0] i_section_ev,
  input wire logic [7:0] i_line_ev,
  input wire logic [7:0] i_path_ev,
  input wire logic [7:0] i_protect_switch_ev,
  input wire logic [6:0] i_tx_cell_ev,
  input wire logic [6:0] i_rx_cell_ev,
  // Timing reference
  input wire logic i_frame_ref_in,
  input wire logic i_one_second_in,
  output logic o_one_second_out,
  // Host interrupt, open drain
  output logic o_host_irq_n,
  output logic o_host_irq_oe_n,
  // Control register, pin enable bit included
  output logic [7:0] o_general_control
);

  // Elaboration check: the frame counter is 16 bits and needs two states
  if (FRAMES < 2 || FRAMES > 65535) begin : g_bad_frames
    $error("tlia_top: FRAMES out of range");
  end

  // Index order: tx, rx, aps, path, line, section
  tlia_l1_if #(.W(8)) l1 [TLIA_NUM_L1] ();

  logic [7:0] gen_q;
  logic [7:0] sum_en_q;
  logic [7:0] en_q [TLIA_NUM_L1];
  logic one_sec_flag_q;
  logic one_sec_in_q;
  logic parity_q;
  logic delin_q;
  logic frame_q;
  logic [15:0] frame_cnt_q;
  logic [7:0] rdata_q;
  logic irq_n_q;
  logic one_sec_out_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Address decode
  wire rd_tx = i_reg_rd && hit(i_reg_addr, TLIA_OFS_TX_CELL_IRQ);
  wire rd_rx = i_reg_rd && hit(i_reg_addr, TLIA_OFS_RX_CELL_IRQ);
  wire rd_sum = i_reg_rd && hit(i_reg_addr, TLIA_OFS_SUMMARY_IRQ);
  wire rd_aps = i_reg_rd && hit(i_reg_addr, TLIA_OFS_PROTECT_SWITCH_IRQ);
  wire rd_pth = i_reg_rd && hit(i_reg_addr, TLIA_OFS_PATH_IRQ);
  wire rd_lin = i_reg_rd && hit(i_reg_addr, TLIA_OFS_LINE_IRQ);
  wire rd_sec = i_reg_rd && hit(i_reg_addr, TLIA_OFS_SECTION_IRQ);
  wire [TLIA_NUM_L1-1:0] rd_l1 = {rd_sec, rd_lin, rd_pth, rd_aps, rd_rx, rd_tx};

  // parity edge is a single event
  // parity error into tx bit 7
  wire parity_rise = i_tx_parity_err && !parity_q;
  // loss and regain into rx bit 7
  wire delin_edge = i_cell_delin_loss ^ delin_q;
  wire frame_rise = i_frame_ref_in && !frame_q;
  wire one_sec_rise = i_one_second_in && !one_sec_in_q;

  wire [7:0] set_vec [TLIA_NUM_L1];
  assign set_vec[0] = {parity_rise, i_tx_cell_ev};
  assign set_vec[1] = {delin_edge, i_rx_cell_ev};
  assign set_vec[2] = i_protect_switch_ev;
  assign set_vec[3] = i_path_ev;
  assign set_vec[4] = i_line_ev;
  assign set_vec[5] = i_section_ev;

  genvar g;
  generate
    for (g = 0; g < TLIA_NUM_L1; g++) begin : g_l1
      assign l1[g].set_ev = set_vec[g];
      assign l1[g].rd_clr = rd_l1[g];
      assign l1[g].en = en_q[g];
      tlia_l1_bank #(.W(8)) u_bank (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .l1(l1[g])
      );
    end
  endgenerate

  wire [7:0] fl [TLIA_NUM_L1];
  wire [TLIA_NUM_L1-1:0] sm;
  generate
    for (g = 0; g < TLIA_NUM_L1; g++) begin : g_tap
      assign fl[g] = l1[g].flags;
      assign sm[g] = l1[g].summary;
    end
  endgenerate

  // summary layout, bit 3 reads zero
  wire [7:0] summary_irq = {sm[5], sm[4], sm[3], one_sec_flag_q, 1'b0, sm[2], sm[1], sm[0]};

  wire irq_active = gen_q[TLIA_BIT_IRQ_PIN_EN] && |(summary_irq & sum_en_q);

  // one-second flag clears on summary read, set wins
  wire one_sec_flag_d = one_sec_rise || (one_sec_flag_q && !rd_sum);

  // frame counter wraps every FRAMES periods
  wire cnt_wrap = frame_cnt_q == 16'(FRAMES - 1);
  wire [15:0] frame_cnt_d = frame_rise ? (cnt_wrap ? 16'h0000 : frame_cnt_q + 16'h0001) : frame_cnt_q;
  wire one_sec_out_d = frame_rise ? cnt_wrap : one_sec_out_q;

  // Read mux, unmapped addresses read zero
  // summary then one register
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    case (i_reg_addr)
      TLIA_OFS_GENERAL_CONTROL: rmux = gen_q;
      TLIA_OFS_TX_CELL_IRQ: rmux = fl[0];
      TLIA_OFS_RX_CELL_IRQ: rmux = fl[1];
      TLIA_OFS_PROTECT_SWITCH_IRQ: rmux = fl[2];
      TLIA_OFS_PATH_IRQ: rmux = fl[3];
      TLIA_OFS_LINE_IRQ: rmux = fl[4];
      TLIA_OFS_SECTION_IRQ: rmux = fl[5];
      TLIA_OFS_SUMMARY_IRQ: rmux = summary_irq;
      TLIA_OFS_SUMMARY_IRQ_EN: rmux = sum_en_q;
      TLIA_OFS_TX_CELL_IRQ_EN: rmux = en_q[0];
      TLIA_OFS_RX_CELL_IRQ_EN: rmux = en_q[1];
      TLIA_OFS_PROTECT_SWITCH_IRQ_EN: rmux = en_q[2];
      TLIA_OFS_PATH_IRQ_EN: rmux = en_q[3];
      TLIA_OFS_LINE_IRQ_EN: rmux = en_q[4];
      TLIA_OFS_SECTION_IRQ_EN: rmux = en_q[5];
      default: rmux = 8'h00;
    endcase
  end

  // Edge detect and timing state
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      parity_q <= 1'b0;
      delin_q <= 1'b0;
      frame_q <= 1'b0;
      one_sec_in_q <= 1'b0;
      frame_cnt_q <= 16'h0000;
      one_sec_out_q <= 1'b0;
      one_sec_flag_q <= 1'b0;
    end else begin
      parity_q <= i_tx_parity_err;
      delin_q <= i_cell_delin_loss;
      frame_q <= i_frame_ref_in;
      one_sec_in_q <= i_one_second_in;
      frame_cnt_q <= frame_cnt_d;
      one_sec_out_q <= one_sec_out_d;
      one_sec_flag_q <= one_sec_flag_d;
    end
  end

  // Writable control and enables
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gen_q <= TLIA_RST_REG;
      sum_en_q <= TLIA_RST_REG;
      for (int k = 0; k < TLIA_NUM_L1; k++) en_q[k] <= TLIA_RST_REG;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        TLIA_OFS_GENERAL_CONTROL: gen_q <= i_reg_wdata;
        TLIA_OFS_SUMMARY_IRQ_EN: sum_en_q <= i_reg_wdata;
        TLIA_OFS_TX_CELL_IRQ_EN: en_q[0] <= i_reg_wdata;
        TLIA_OFS_RX_CELL_IRQ_EN: en_q[1] <= i_reg_wdata;
        TLIA_OFS_PROTECT_SWITCH_IRQ_EN: en_q[2] <= i_reg_wdata;
        TLIA_OFS_PATH_IRQ_EN: en_q[3] <= i_reg_wdata;
        TLIA_OFS_LINE_IRQ_EN: en_q[4] <= i_reg_wdata;
        TLIA_OFS_SECTION_IRQ_EN: en_q[5] <= i_reg_wdata;
        default: gen_q <= gen_q;
      endcase
    end
  end

  // Registered outputs; read data captured in the cycle of the strobe
  // pin low while interrupt active
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 8'h00;
      irq_n_q <= 1'b1;
    end else begin
      rdata_q <= i_reg_rd ? rmux : rdata_q;
      irq_n_q <= !irq_active;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_host_irq_n = irq_n_q;
  // Open drain: enable low only while pulling low
  assign o_host_irq_oe_n = irq_n_q;
  assign o_one_second_out = one_sec_out_q;
  assign o_general_control = gen_q;

endmodule
`default_nettype wire

// ### tlia_pkg.sv
// Constants for the two-level interrupt aggregator.
// Assumes an 8-bit register port with 8-bit addresses.
package tlia_pkg;

  // Register offsets
  localparam logic [7:0] TLIA_OFS_GENERAL_CONTROL = 8'h00;
  localparam logic [7:0] TLIA_OFS_TX_CELL_IRQ = 8'h40;
  localparam logic [7:0] TLIA_OFS_RX_CELL_IRQ = 8'h41;
  localparam logic [7:0] TLIA_OFS_SUMMARY_IRQ = 8'h42;
  localparam logic [7:0] TLIA_OFS_SUMMARY_IRQ_EN = 8'h43;
  localparam logic [7:0] TLIA_OFS_SECTION_IRQ = 8'h44;
  localparam logic [7:0] TLIA_OFS_LINE_IRQ = 8'h45;
  localparam logic [7:0] TLIA_OFS_PATH_IRQ = 8'h46;
  localparam logic [7:0] TLIA_OFS_PROTECT_SWITCH_IRQ = 8'h47;
  localparam logic [7:0] TLIA_OFS_SECTION_IRQ_EN = 8'h48;
  localparam logic [7:0] TLIA_OFS_LINE_IRQ_EN = 8'h49;
  localparam logic [7:0] TLIA_OFS_PATH_IRQ_EN = 8'h4A;
  localparam logic [7:0] TLIA_OFS_PROTECT_SWITCH_IRQ_EN = 8'h4B;
  localparam logic [7:0] TLIA_OFS_TX_CELL_IRQ_EN = 8'h4C;
  localparam logic [7:0] TLIA_OFS_RX_CELL_IRQ_EN = 8'h4D;

  // Field positions
  localparam int TLIA_BIT_IRQ_PIN_EN = 6;
  localparam int TLIA_BIT_PARITY = 7;
  localparam int TLIA_BIT_DELIN = 7;
  localparam int TLIA_SUM_TX = 0;
  localparam int TLIA_SUM_RX = 1;
  localparam int TLIA_SUM_APS = 2;
  localparam int TLIA_SUM_ONE_SEC = 4;
  localparam int TLIA_SUM_PATH = 5;
  localparam int TLIA_SUM_LINE = 6;
  localparam int TLIA_SUM_SECTION = 7;

  // Reset values
  localparam logic [7:0] TLIA_RST_REG = 8'h00;

  // One-second reference: frame periods per second
  localparam int TLIA_FRAMES_PER_SEC = 8000;

  // First-level register count
  localparam int TLIA_NUM_L1 = 6;

endpackage

// ### tlia_l1_if.sv
// Carrier between the top and the first-level latch bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface tlia_l1_if #(parameter int W = 8);
  logic [W-1:0] set_ev;
  logic rd_clr;
  logic [W-1:0] en;
  logic [W-1:0] flags;
  logic summary;
  modport bank (input set_ev, input rd_clr, input en, output flags, output summary);
  modport ctrl (output set_ev, output rd_clr, output en, input flags, input summary);
endinterface
`default_nettype wire

// ### tlia_l1_bank.sv
// One first-level interrupt register with its enable mask.
// Assumes event pulses and read strobe are synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module tlia_l1_bank
  import tlia_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Link to the top
  tlia_l1_if.bank l1
);

  // Elaboration check: the carrier holds at most one byte
  if (W < 1 || W > 8) begin : g_bad_width
    $error("tlia_l1_bank: width must be 1..8");
  end

  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  // set wins over a same-cycle read clear
  assign flags_d = (l1.rd_clr ? '0 : flags_q) | l1.set_ev;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign l1.flags = flags_q;
  assign l1.summary = |(flags_q & l1.en);

endmodule
`default_nettype wire

// ### tlia_top_assertions.sv
// Checker for tlia_top: read clearing, summary layout, pin and one-second timing.
// Assumes it is bound into tlia_top and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module tlia_chk
  import tlia_pkg::*;
#(
  parameter int FRAMES = TLIA_FRAMES_PER_SEC
) (
  // Clock, reset and register port
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] o_reg_rdata,
  // Sources and outputs
  input wire logic i_tx_parity_err,
  input wire logic [6:0] i_tx_cell_ev,
  input wire logic i_one_second_in,
  input wire logic o_one_second_out,
  input wire logic o_host_irq_n,
  input wire logic o_host_irq_oe_n,
  input wire logic [7:0] o_general_control
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // Decodes; a tx read only counts while no tx source moves
  wire rd_tx = i_reg_rd && (i_reg_addr == TLIA_OFS_TX_CELL_IRQ) && (i_tx_cell_ev == 7'h00);
  wire rd_sum = i_reg_rd && (i_reg_addr == TLIA_OFS_SUMMARY_IRQ);
  wire pin_en = o_general_control[TLIA_BIT_IRQ_PIN_EN];
  a_tx_read_clears: assert property ((rd_tx && $stable(i_tx_parity_err)) [*2] |=> o_reg_rdata == 8'h00)
    else $error("tx bits survive a read");
  a_sum_after_tx: assert property ((rd_tx && $stable(i_tx_parity_err)) ##1 rd_sum
    |=> !o_reg_rdata[TLIA_SUM_TX]) else $error("tx summary stays after tx read");
  a_sum_bit3: assert property (rd_sum |=> !o_reg_rdata[3])
    else $error("reserved summary bit set");
  a_sec_read_clears: assert property ((rd_sum && $stable(i_one_second_in)) [*2] |=> !o_reg_rdata[4])
    else $error("one-second bit survives a read");
  a_pin_gate: assert property ((!pin_en) [*2] |=> o_host_irq_n)
    else $error("pin low while disabled");
  a_oe_tracks: assert property (o_host_irq_oe_n == o_host_irq_n)
    else $error("pin enable differs from level");
  a_second_high: assert property ($rose(o_one_second_out) |-> o_one_second_out [*4])
    else $error("one-second pulse too short");
  a_second_low: assert property ($fell(o_one_second_out) |-> (!o_one_second_out) [*8])
    else $error("one-second pulse too soon");
  // Main scenarios
  c_tx_twice: cover property (rd_tx [*2]);
  c_second: cover property ($rose(o_one_second_out));
  c_pin: cover property ($fell(o_host_irq_n));
endmodule
bind tlia_top tlia_chk #(.FRAMES(FRAMES)) u_tlia_chk (.i_sys_clk, .i_nrst, .i_reg_rd, .i_reg_addr,
  .o_reg_rdata, .i_tx_parity_err, .i_tx_cell_ev, .i_one_second_in, .o_one_second_out,
  .o_host_irq_n, .o_host_irq_oe_n, .o_general_control);
`default_nettype wire

// ### tlia_host.sv
// Host model: drives the register port, one bus cycle per op call, three per service call.
// Assumes callers start 1 ns after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module tlia_host
  import tlia_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Register port toward the device
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  // Idle lines flip so a stale value never looks fresh
  task automatic op(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    o_rd = r;
    o_wr = w;
    o_addr = (r | w) ? a : ~a;
    o_wdata = w ? d : ~d;
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic service(input logic [7:0] a);
    op(1'b1, 1'b0, TLIA_OFS_SUMMARY_IRQ, 8'h00);
    op(1'b1, 1'b0, a, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
endmodule
`default_nettype wire

// ### tlia_top_test.sv
// Bench for tlia_top: reads, sources, pin and one-second pulse.
// Assumes tlia_host owns the register port.
`timescale 1ns/100ps
`default_nettype none
module tlia_top_test
  import tlia_pkg::*;
;
  logic clk, nrst, par, dl, frame, gate, rd1;
  logic [6:0] txe, rxe, rxv;
  logic [7:0] en [4], ev [4], evp [4], s;
  logic [7:0] exq [$];
  int n_errors, n_compared, k, c;
  int pos [4] = '{TLIA_SUM_SECTION, TLIA_SUM_LINE, TLIA_SUM_PATH, TLIA_SUM_APS};
  wire rd, wr, osec, oe_n, irq_n;
  wire [7:0] addr, wdata, rdata, gctl;
  // Pull-up on the open-drain pin; the level counts only while driven
  wire irq = oe_n ? 1'b1 : irq_n;
  tlia_host u_tlia_host (.i_sys_clk(clk), .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
  // Four frames a second keeps the run short
  tlia_top #(.FRAMES(4)) u_tlia_top (.i_sys_clk(clk), .i_nrst(nrst), .i_reg_rd(rd), .i_reg_wr(wr),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_tx_parity_err(par),
    .i_cell_delin_loss(dl), .i_section_ev(evp[0]), .i_line_ev(evp[1]), .i_path_ev(evp[2]),
    .i_protect_switch_ev(evp[3]), .i_tx_cell_ev(txe), .i_rx_cell_ev(rxe), .i_frame_ref_in(frame),
    .i_one_second_in(gate & osec), .o_one_second_out(osec), .o_host_irq_n(irq_n), .o_host_irq_oe_n(oe_n),
    .o_general_control(gctl));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exq.push_back(e);
    u_tlia_host.op(1'b1, 1'b0, a, 8'h00);
  endtask
  task automatic wrx(input logic [7:0] a, input logic [7:0] d);
    u_tlia_host.op(1'b0, 1'b1, a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) u_tlia_host.op(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  // Bounded wait; c holds the cycles spent
  task automatic wl(input logic v);
    c = 0;
    while (osec !== v && c < 200) begin
      idle(1);
      c++;
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Clock, and a frame reference of eight clocks
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    frame = 1'b0;
    forever begin
      repeat (4) @(posedge clk);
      #1 frame = ~frame;
    end
  end
  // Read data is taken at the read edge; look mid-cycle before a following read replaces it
  always @(posedge clk) begin
    rd1 <= rd;
  end
  always @(negedge clk) begin
    if (rd1 === 1'b1) begin
      check("read data", rdata, exq.pop_front());
    end
  end
  // Well above the 174 cycles the tests need
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {nrst, par, dl, gate, txe, rxe} = '0;
    evp = '{default: 8'h00};
    void'($urandom(62));
    idle(4);
    nrst = 1'b1;
    rdx(TLIA_OFS_GENERAL_CONTROL, 8'h00);
    for (k = 8'h40; k <= 8'h4D; k++) rdx(8'(k), 8'h00);
    rdx(8'h10, 8'h00);
    wrx(TLIA_OFS_GENERAL_CONTROL, 8'h40);
    wrx(TLIA_OFS_SUMMARY_IRQ_EN, 8'hFF);
    wrx(TLIA_OFS_TX_CELL_IRQ_EN, 8'hFF);
    rdx(TLIA_OFS_GENERAL_CONTROL, 8'h40);
    check("ctl out", gctl, 8'h40);
    s = 8'h00;
    for (k = 0; k < 4; k++) begin
      {en[k], ev[k]} = 16'($urandom);
      wrx(8'(TLIA_OFS_SECTION_IRQ_EN + k), en[k]);
      rdx(8'(TLIA_OFS_SECTION_IRQ_EN + k), en[k]);
      s[pos[k]] = |(ev[k] & en[k]);
    end
    // One-cycle pulse on the section, line, path and protect-switch groups at once
    evp = ev;
    idle(1);
    evp = '{default: 8'h00};
    idle(2);
    for (k = 0; k < 4; k++) begin
      exq.push_back(s);
      exq.push_back(ev[k]);
      u_tlia_host.service(8'(TLIA_OFS_SECTION_IRQ + k));
      s[pos[k]] = 1'b0;
    end
    rdx(TLIA_OFS_SECTION_IRQ, 8'h00);
    par = 1'b1;
    idle(3);
    rdx(TLIA_OFS_TX_CELL_IRQ, 8'h80);
    rdx(TLIA_OFS_TX_CELL_IRQ, 8'h00);
    par = 1'b0;
    idle(3);
    rdx(TLIA_OFS_TX_CELL_IRQ, 8'h00);
    dl = 1'b1;
    idle(3);
    rdx(TLIA_OFS_RX_CELL_IRQ, 8'h80);
    rdx(TLIA_OFS_RX_CELL_IRQ, 8'h00);
    dl = 1'b0;
    idle(3);
    rdx(TLIA_OFS_RX_CELL_IRQ, 8'h80);
    // Receive cell sources reach summary bit 1 while enabled
    wrx(TLIA_OFS_RX_CELL_IRQ_EN, 8'h7F);
    rxv = 7'($urandom) | 7'h01;
    rxe = rxv;
    idle(1);
    rxe = 7'h00;
    idle(1);
    rdx(TLIA_OFS_SUMMARY_IRQ, 8'h02);
    rdx(TLIA_OFS_RX_CELL_IRQ, {1'b0, rxv});
    rdx(TLIA_OFS_SUMMARY_IRQ, 8'h00);
    // Pin follows the enabled summary and the pin enable
    txe = 7'h01;
    idle(1);
    txe = 7'h00;
    idle(3);
    check("pin", irq, 1'b0);
    wrx(TLIA_OFS_GENERAL_CONTROL, 8'h00);
    idle(3);
    check("pin off", irq, 1'b1);
    wrx(TLIA_OFS_GENERAL_CONTROL, 8'h40);
    wrx(TLIA_OFS_SUMMARY_IRQ_EN, 8'h00);
    idle(3);
    check("sum mask", irq, 1'b1);
    wrx(TLIA_OFS_SUMMARY_IRQ_EN, 8'hFF);
    wrx(TLIA_OFS_TX_CELL_IRQ_EN, 8'h00);
    idle(3);
    check("tx mask", irq, 1'b1);
    wrx(TLIA_OFS_TX_CELL_IRQ_EN, 8'hFF);
    rdx(TLIA_OFS_TX_CELL_IRQ, 8'h01);
    rdx(TLIA_OFS_SUMMARY_IRQ, 8'h00);
    idle(3);
    check("pin free", irq, 1'b1);
    wl(1'b0);
    wl(1'b1);
    wl(1'b0);
    check("second high", 8'(c), 8'h08);
    gate = 1'b1;
    wl(1'b1);
    check("second low", 8'(c), 8'h18);
    idle(4);
    rdx(TLIA_OFS_SUMMARY_IRQ, 8'h10);
    rdx(TLIA_OFS_SUMMARY_IRQ, 8'h00);
    idle(3);
    // Mid-run reset drops a pending interrupt and all control
    txe = 7'h01;
    idle(1);
    txe = 7'h00;
    idle(2);
    check("pin set", irq, 1'b0);
    nrst = 1'b0;
    idle(2);
    check("ctl reset", gctl, 8'h00);
    check("pin reset", irq, 1'b1);
    nrst = 1'b1;
    rdx(TLIA_OFS_TX_CELL_IRQ, 8'h00);
    rdx(TLIA_OFS_SUMMARY_IRQ_EN, 8'h00);
    idle(1);
    check("queue", 8'(exq.size()), 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
